// >>> src/fgw_pkg.sv
// package of constants and carriers for the fieldbus gateway status/address block
package fgw_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	// flash rates in hertz
	localparam int unsigned FLASH_HW_HZ   = 4;
	localparam int unsigned FLASH_IO_HZ   = 2;
	localparam int unsigned FLASH_LINK_HZ = 2;
	localparam int unsigned FLASH_CMD_HZ  = 1;
	// half-period counts (50 percent duty)
	localparam int unsigned HALF_4HZ      = CLK_HZ / (2 * FLASH_HW_HZ);
	localparam int unsigned HALF_2HZ      = CLK_HZ / (2 * FLASH_IO_HZ);
	localparam int unsigned HALF_1HZ      = CLK_HZ / (2 * FLASH_CMD_HZ);
	// bit rate range in bit/s
	localparam int unsigned BAUD_MIN      = 9_600;
	localparam int unsigned BAUD_MAX      = 6_000_000;
	localparam int unsigned BIT_MAX_CYC   = CLK_HZ / BAUD_MIN;
	localparam int unsigned BIT_MIN_CYC   = CLK_HZ / BAUD_MAX;
	localparam int unsigned CNT_W         = 28;
	localparam int unsigned ADDR_W        = 7;
	localparam logic [6:0]  ADDR_MAX      = 7'h7E;
	localparam logic [6:0]  ADDR_RESET    = 7'h7E;

	typedef enum logic [2:0] {
		FGW_PM_OK   = 3'b000,
		FGW_PM_CMD  = 3'b001,
		FGW_PM_LINK = 3'b011,
		FGW_PM_IO   = 3'b010,
		FGW_PM_HW   = 3'b110
	} fgw_pm_e;

	typedef struct packed {
		logic hw_fault;
		logic io_count_err;
		logic base_link_err;
		logic net_cmd_err;
	} fgw_fault_s;

	typedef struct packed {
		logic red;
		logic green;
	} fgw_led_s;
endpackage

// >>> src/fgw_status_addr.sv
// status, node address and bit rate detection of the fieldbus gateway
`timescale 1ns/100ps
module fgw_status_addr (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// switches
	input  wire logic [7:0]         addr_switch,
	// network line receive level and frame status
	input  wire logic               net_rx,
	input  wire logic               net_msg_ok,
	input  wire logic               net_connected,
	// base unit link
	input  wire logic [7:0]         base_rx_data,
	input  wire logic               base_rx_valid,
	output logic [7:0]              base_tx_data,
	output logic                    base_tx_valid,
	// fault inputs
	input  fgw_pkg::fgw_fault_s     faults,
	// results
	output logic [6:0]              node_addr,
	output logic                    node_addr_valid,
	output logic                    baud_locked,
	output logic [fgw_pkg::CNT_W-1:0] bit_cycles,
	output logic                    net_tx_en,
	// lamps
	output fgw_pkg::fgw_led_s       pm_led,
	output fgw_pkg::fgw_led_s       bus_led
);
	import fgw_pkg::*;

	logic [CNT_W-1:0] div4_r, div2_r, div1_r;
	logic             ph4_r, ph2_r, ph1_r;
	logic [CNT_W-1:0] run_r, min_r;
	logic             rx_d_r;
	fgw_pm_e          pm_r;
	fgw_led_s         pm_nxt;

	// slave only, the driver is never enabled
	always_ff @(posedge mclk) begin
		net_tx_en <= 1'b0;
	end

	// base link relay, one cycle of latency
	always_ff @(posedge mclk) begin
		if (rst) begin
			base_tx_data  <= 8'h00;
			base_tx_valid <= 1'b0;
		end else begin
			base_tx_data  <= base_rx_data;
			base_tx_valid <= base_rx_valid;
		end
	end

	// switch 8 dropped, 127 refused; last good address kept
	always_ff @(posedge mclk) begin
		if (rst) begin
			node_addr       <= ADDR_RESET;
			node_addr_valid <= 1'b0;
		end else begin
			node_addr_valid <= (addr_switch[6:0] <= ADDR_MAX);
			if (addr_switch[6:0] <= ADDR_MAX)
				node_addr <= addr_switch[6:0];
		end
	end

	// shortest pulse between line edges is one bit time
	// idle since reset counts as a pulse too; a real line idles longer than one bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_d_r      <= 1'b1;
			run_r       <= '0;
			min_r       <= CNT_W'(BIT_MAX_CYC);
			baud_locked <= 1'b0;
			bit_cycles  <= CNT_W'(BIT_MAX_CYC);
		end else begin
			rx_d_r <= net_rx;
			if (net_rx != rx_d_r) begin
				run_r <= '0;
				// pulses outside the rate range are ignored as noise or idle
				if (run_r >= CNT_W'(BIT_MIN_CYC - 1) && run_r < min_r)
					min_r <= run_r + 1'b1;
			end else if (run_r != {CNT_W{1'b1}}) begin
				run_r <= run_r + 1'b1;
			end
			if (net_msg_ok && !baud_locked) begin
				baud_locked <= 1'b1;
				bit_cycles  <= min_r;
			end
		end
	end

	// free-running 50 percent dividers
	always_ff @(posedge mclk) begin
		if (rst) begin
			div4_r <= '0;
			div2_r <= '0;
			div1_r <= '0;
			ph4_r  <= 1'b0;
			ph2_r  <= 1'b0;
			ph1_r  <= 1'b0;
		end else begin
			div4_r <= (div4_r == CNT_W'(HALF_4HZ - 1)) ? '0 : div4_r + 1'b1;
			div2_r <= (div2_r == CNT_W'(HALF_2HZ - 1)) ? '0 : div2_r + 1'b1;
			div1_r <= (div1_r == CNT_W'(HALF_1HZ - 1)) ? '0 : div1_r + 1'b1;
			if (div4_r == CNT_W'(HALF_4HZ - 1))
				ph4_r <= ~ph4_r;
			if (div2_r == CNT_W'(HALF_2HZ - 1))
				ph2_r <= ~ph2_r;
			if (div1_r == CNT_W'(HALF_1HZ - 1))
				ph1_r <= ~ph1_r;
		end
	end

	// worst fault wins
	always_ff @(posedge mclk) begin
		if (rst)
			pm_r <= FGW_PM_OK;
		else if (faults.hw_fault)
			pm_r <= FGW_PM_HW;
		else if (faults.io_count_err)
			pm_r <= FGW_PM_IO;
		else if (faults.base_link_err)
			pm_r <= FGW_PM_LINK;
		else if (faults.net_cmd_err)
			pm_r <= FGW_PM_CMD;
		else
			pm_r <= FGW_PM_OK;
	end

	always_comb begin
		pm_nxt = '{red: 1'b0, green: 1'b1};
		unique case (pm_r)
			FGW_PM_OK:   pm_nxt = '{red: 1'b0, green: 1'b1};
			FGW_PM_HW:   pm_nxt = '{red: ph4_r, green: ph4_r};
			FGW_PM_IO:   pm_nxt = '{red: ph2_r, green: ph2_r};
			FGW_PM_LINK: pm_nxt = '{red: ph2_r, green: 1'b0};
			FGW_PM_CMD:  pm_nxt = '{red: ph1_r, green: 1'b0};
			default:     pm_nxt = '{red: 1'b1, green: 1'b1};
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pm_led  <= '{red: 1'b0, green: 1'b0};
			bus_led <= '{red: 1'b0, green: 1'b0};
		end else begin
			pm_led  <= pm_nxt;
			// bus lamp never shows red on this gateway
			bus_led <= '{red: 1'b0, green: net_connected && baud_locked};
		end
	end

	chk_addr_drop_bit8: assert property (@(posedge mclk) disable iff (rst)
		$changed(addr_switch[7]) && $stable(addr_switch[6:0]) |=> $stable(node_addr))
		else $error("switch 8 changed the node address");
	chk_addr_follows: assert property (@(posedge mclk) disable iff (rst)
		addr_switch[6:0] <= ADDR_MAX |=> node_addr == $past(addr_switch[6:0]))
		else $error("node address does not follow switches");
	chk_addr_range: assert property (@(posedge mclk) disable iff (rst)
		node_addr_valid |-> node_addr <= ADDR_MAX)
		else $error("node address beyond 126");
	chk_never_master: assert property (@(posedge mclk) disable iff (rst)
		!net_tx_en)
		else $error("line driver enabled");
	chk_base_relay: assert property (@(posedge mclk) disable iff (rst)
		base_rx_valid |=> base_tx_valid && base_tx_data == $past(base_rx_data))
		else $error("base link word lost");
	chk_lock_range: assert property (@(posedge mclk) disable iff (rst)
		baud_locked |-> bit_cycles >= CNT_W'(BIT_MIN_CYC) && bit_cycles <= CNT_W'(BIT_MAX_CYC))
		else $error("locked bit time out of range");
	chk_lock_on_msg: assert property (@(posedge mclk) disable iff (rst)
		net_msg_ok |=> baud_locked)
		else $error("no lock after good message");
	sequence s_hw_held;
		faults.hw_fault [*2];
	endsequence
	chk_hw_yellow: assert property (@(posedge mclk) disable iff (rst)
		s_hw_held |=> pm_led.red == pm_led.green)
		else $error("hardware fault not yellow");
	chk_link_red: assert property (@(posedge mclk) disable iff (rst)
		!faults.hw_fault && !faults.io_count_err && faults.base_link_err ##1 $stable(faults) |=> !pm_led.green)
		else $error("base link fault shows green");
	chk_ok_green: assert property (@(posedge mclk) disable iff (rst)
		faults == '0 ##1 faults == '0 |=> pm_led.green && !pm_led.red)
		else $error("normal state not steady green");
	chk_bus_dark: assert property (@(posedge mclk) disable iff (rst)
		!net_connected |=> !bus_led.green && !bus_led.red)
		else $error("bus lamp lit while disconnected");
	chk_bus_green: assert property (@(posedge mclk) disable iff (rst)
		net_connected && baud_locked |=> bus_led.green)
		else $error("bus lamp dark while connected");
	chk_flash_duty: assert property (@(posedge mclk) disable iff (rst)
		$changed(ph4_r) |-> div4_r == '0)
		else $error("flash phase off period edge");
	chk_io_rank: assert property (@(posedge mclk) disable iff (rst)
		!faults.hw_fault && faults.io_count_err |=> pm_r == FGW_PM_IO)
		else $error("io count fault not shown");
	chk_cmd_red: assert property (@(posedge mclk) disable iff (rst)
		faults == 4'b0001 |=> pm_r == FGW_PM_CMD)
		else $error("command fault not shown");
	chk_lock_holds: assert property (@(posedge mclk) disable iff (rst)
		baud_locked |=> baud_locked && $stable(bit_cycles))
		else $error("locked bit time changed");
	chk_bus_needs_lock: assert property (@(posedge mclk) disable iff (rst)
		!baud_locked |=> !bus_led.green && !bus_led.red)
		else $error("bus lamp lit before lock");
endmodule // fgw_status_addr

// >>> test/fgw_dp_master_model.sv
// behavioural network master that drives the gateway's line inputs
`timescale 1ns/100ps
module fgw_dp_master_model (
	// clock
	input  wire logic mclk,
	// line side seen by the gateway
	output logic      net_rx,
	output logic      net_msg_ok,
	output logic      net_connected
);
	initial begin
		net_rx = 1'b1;
		net_msg_ok = 1'b0;
		net_connected = 1'b0;
	end
	// even toggle count so the line idles high after a frame
	task automatic frame(input int bit_len, input int n_bits);
		for (int i = 0; i < n_bits; i++) begin
			net_rx = ~net_rx;
			repeat (bit_len) @(negedge mclk);
		end
		net_msg_ok = 1'b1;
		@(negedge mclk);
		net_msg_ok = 1'b0;
		@(negedge mclk);
	endtask
	task automatic set_link(input logic c);
		net_connected = c;
	endtask
endmodule // fgw_dp_master_model

// >>> test/fgw_status_addr_tb.sv
// self-checking bench of the gateway status and address block
`timescale 1ns/100ps
module fgw_status_addr_tb;
	import fgw_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr_switch = 8'h00;
	logic [7:0]  base_rx_data = 8'h00;
	logic        base_rx_valid = 1'b0;
	fgw_fault_s  faults = '0;
	logic        net_rx, net_msg_ok, net_connected, node_addr_valid, baud_locked, net_tx_en, base_tx_valid;
	logic [7:0]  base_tx_data;
	logic [6:0]  node_addr, last_addr;
	logic [27:0] bit_cycles;
	fgw_led_s    pm_led, bus_led;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          bit_len;
	logic [7:0]  corners [5] = '{8'h7F, 8'hFE, 8'h00, 8'h80, 8'h7E};
	fgw_dp_master_model dp (.mclk(mclk), .net_rx(net_rx), .net_msg_ok(net_msg_ok), .net_connected(net_connected));
	fgw_status_addr uut (.mclk(mclk), .rst(rst), .addr_switch(addr_switch), .net_rx(net_rx),
		.net_msg_ok(net_msg_ok), .net_connected(net_connected), .base_rx_data(base_rx_data),
		.base_rx_valid(base_rx_valid), .base_tx_data(base_tx_data), .base_tx_valid(base_tx_valid),
		.faults(faults), .node_addr(node_addr), .node_addr_valid(node_addr_valid),
		.baud_locked(baud_locked), .bit_cycles(bit_cycles), .net_tx_en(net_tx_en),
		.pm_led(pm_led), .bus_led(bus_led));
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// worst fault wins: hardware, I/O count, base link, network command
	function automatic fgw_pm_e exp_pm(input fgw_fault_s f);
		if (f.hw_fault)
			return FGW_PM_HW;
		if (f.io_count_err)
			return FGW_PM_IO;
		if (f.base_link_err)
			return FGW_PM_LINK;
		if (f.net_cmd_err)
			return FGW_PM_CMD;
		return FGW_PM_OK;
	endfunction
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, whole sequence needs well under this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'hE3FC119D));
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check({node_addr, node_addr_valid, baud_locked}, {7'h7E, 2'b00});
		check(bit_cycles, 28'd20833);
		last_addr = 7'h7E;
		for (int i = 0; i < 40; i++) begin
			// lone slave on this segment, so any address is unique
			addr_switch = (i < 5) ? corners[i] : 8'($urandom());
			@(negedge mclk);
			if (addr_switch[6:0] != 7'h7F)
				last_addr = addr_switch[6:0];
			check({node_addr, node_addr_valid}, {last_addr, addr_switch[6:0] != 7'h7F});
		end
		$display("test address done");
		for (int i = 0; i < 40; i++) begin
			base_rx_valid = 1'($urandom());
			base_rx_data = 8'($urandom());
			@(negedge mclk);
			check({base_tx_valid, base_tx_data & {8{base_rx_valid}}}, {base_rx_valid, base_rx_data & {8{base_rx_valid}}});
		end
		base_rx_valid = 1'b0;
		$display("test base link done");
		dp.set_link(1'b1);
		repeat (2) @(negedge mclk);
		check(bus_led, 2'b00);
		// first good message locks; later messages are refused
		dp.frame(60, 4);
		check({baud_locked, bit_cycles}, {1'b1, 28'h000003C});
		dp.frame(90, 4);
		dp.frame(40, 4);
		check({baud_locked, bit_cycles}, {1'b1, 28'h000003C});
		check({net_tx_en, bus_led}, 3'b001);
		dp.set_link(1'b0);
		repeat (2) @(negedge mclk);
		check(bus_led, 2'b00);
		$display("test bit rate done");
		check(pm_led, 2'b01);
		for (int f = 1; f < 16; f++) begin
			faults = 4'(f);
			repeat (3) @(negedge mclk);
			check(pm_led, 2'b00);
			check(uut.pm_r, exp_pm(faults));
		end
		faults = '0;
		repeat (3) @(negedge mclk);
		check(pm_led, 2'b01);
		$display("test lamps done");
		// second reset in mid-run, then lock again at a random bit time
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check({baud_locked, bit_cycles}, {1'b0, 28'h0005161});
		check({node_addr, node_addr_valid}, {7'h7E, 1'b0});
		check({pm_led, bus_led}, 4'h0);
		bit_len = 33 + int'($urandom() % 100);
		dp.frame(bit_len, 4);
		check({baud_locked, bit_cycles}, {1'b1, 28'(bit_len)});
		$display("test reset relock done");
		print_verdict();
	end
endmodule // fgw_status_addr_tb
